// ---- wtio_far_end.sv ----
// Model of the test equipment that drives the trigger pins.
`timescale 1ns/1ps
`default_nettype none
module wtio_far_end (
  input wire logic i_clk,
  input wire logic [3:0] i_fire,
  input wire logic i_slow,
  output logic o_frame_sync,
  output logic o_tpc_trig,
  output logic o_cm_start,
  output logic o_cm_stop
);
  logic [3:0] hold [4] = '{default: 4'h0};

  // Each request bit raises its own pin for a while; a slow source holds it
  // longer, since real equipment gives no promise on pulse width.
  always_ff @(posedge i_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (i_fire[k]) begin
        hold[k] <= i_slow ? 4'hc : 4'h4;
      end else if (hold[k] != 4'h0) begin
        hold[k] <= hold[k] - 4'h1;
      end
    end
  end

  // Frame clock edges come only when asked, never at a period of their own.
  assign o_frame_sync = hold[0] != 4'h0;
  assign o_tpc_trig = hold[1] != 4'h0;
  assign o_cm_start = hold[2] != 4'h0;
  assign o_cm_stop = hold[3] != 4'h0;
endmodule
`default_nettype wire

// ---- wtio_pkg.sv ----
// Shared constants and types for the uplink timing and trigger block.
package wtio_pkg;

  // Register port geometry and register offsets.
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OUT_SEL = 8'h04;
  localparam logic [7:0] REG_CHIP_INC = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;

  // Field positions of the control and status registers.
  localparam int CTRL_SYNC_SRC_BIT = 0;
  localparam int CTRL_PERIOD_LSB = 1;
  localparam int CTRL_FMT_LSB = 4;
  localparam int CTRL_TTI_LSB = 7;
  localparam int STAT_COMP_BIT = 12;
  localparam int STAT_CMREQ_BIT = 13;
  localparam int OUT_SEL_W = 4;

  // Values after reset.
  localparam logic [27:0] OUT_SEL_RST = 28'h7140032;

  // Clock rates; the chip clock comes from a 32-bit phase accumulator.
  localparam logic [63:0] CLK_HZ = 64'd200000000;
  localparam logic [63:0] CHIP_HZ = 64'd3840000;
  localparam logic [63:0] CHIP_INC_FULL = (CHIP_HZ << 32) / CLK_HZ;
  localparam logic [31:0] CHIP_INC_RST = CHIP_INC_FULL[31:0];

  // Frame structure in chips: 15 slots of 2560 chips make 10 ms.
  localparam logic [11:0] SLOT_CHIP_LAST = 12'h9ff;
  localparam logic [3:0] SLOT_LAST = 4'he;
  localparam logic [2:0] FMT_MAX = 3'h6;
  localparam logic [3:0] CTRL_BIT_LAST = 4'h9;
  localparam int TPC_W = 2;
  localparam int CTRL_FIELD_W = 8;
  localparam int SFN_W = 12;

  // How the frame sync trigger is read.
  typedef enum logic {
    SYNC_FRAME_CLK = 1'b0,
    SYNC_SFN_RESET = 1'b1
  } wtio_sync_src_t;

  // Period of the frame clock on the sync input.
  typedef enum logic [2:0] {
    FCLK_10MS = 3'b000,
    FCLK_20MS = 3'b001,
    FCLK_40MS = 3'b010,
    FCLK_80MS = 3'b011,
    FCLK_2560MS = 3'b100
  } wtio_fclk_t;

  // Signals that a user-assignable output port can carry.
  typedef enum logic [3:0] {
    out_sel_none = 4'b0000,
    out_sel_chip_clk = 4'b0001,
    out_sel_data_ch_bits = 4'b0010,
    out_sel_data_ch_clk = 4'b0011,
    out_sel_ctrl_ch_bits = 4'b0100,
    out_sel_ctrl_ch_clk = 4'b0101,
    out_sel_frame_pulse = 4'b0110,
    out_sel_sync_reply = 4'b0111,
    out_sel_compressed_flag = 4'b1000,
    out_sel_tti_pulse = 4'b1001,
    out_sel_cfn_zero_pulse = 4'b1010,
    out_sel_frame80_pulse = 4'b1011
  } wtio_out_sel_t;

endpackage

// ---- wtio_top.sv ----
// Uplink channel timing generator with trigger inputs and event outputs.
// Contract
// - Every dedicated trigger and data output changes only at the chip clock edge; user ports also change when reselected.
// - Sync input acts as frame clock or frame number reset, per setting.
// - Frame clock period is 10, 20, 40, 80 or 2560 ms.
// - TPC trigger makes the next user TPC bits take effect.
// - A compressed mode start trigger enters compressed mode.
// - A compressed mode stop trigger leaves compressed mode, unless a start trigger comes in the same cycle.
// - Chip clock output defaults to 3.84 MHz after reset.
// - One sync reply pulse per sync trigger, none without one.
// - Serial data channel bits go out before spreading.
// - Serial control channel bits go out before spreading.
// - Data channel bit clock rate follows the slot format.
// - Control channel bit clock runs at 15 kHz.
// - A pulse marks each 10 ms frame boundary.
// - A pulse marks each transmission time interval boundary.
// - A pulse marks the frame whose connection frame number is zero.
// - Compressed flag is low for normal frames, high for compressed.
`timescale 1ns/1ps
`default_nettype none

// Word FIFO between the data source and the bit serialiser.
module wtio_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  import wtio_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire logic push;
  wire logic pop;
  wire logic [AW:0] next_count;

  // Handshakes on both sides; full and empty are held in flip-flops.
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign o_out_data = mem[rd_ptr];

  // Pointers wrap naturally, so the depth must be a power of two.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= next_count;
      o_in_ready <= next_count != (AW+1)'(DEPTH);
      o_out_valid <= next_count != '0;
    end
  end

  // Storage needs no reset; only words already counted are ever read.
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end
endmodule

// Timing and trigger logic of the uplink channel generator.
module wtio_top #(
  parameter int DATA_W = 8,
  parameter int FIFO_DEPTH = 16,
  parameter int N_USER = 7
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_frame_sync,
  input wire logic i_tpc_trig,
  input wire logic i_cm_start,
  input wire logic i_cm_stop,
  input wire logic [wtio_pkg::TPC_W-1:0] i_tpc_user_bits,
  input wire logic [wtio_pkg::CTRL_FIELD_W-1:0] i_ctrl_fields,
  input wire logic i_data_valid,
  input wire logic [DATA_W-1:0] i_data,
  output logic o_data_ready,
  input wire logic [wtio_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_chip_clk,
  output logic o_sync_reply,
  output logic o_dpdch_bit,
  output logic o_dpdch_clk,
  output logic o_dpcch_bit,
  output logic o_dpcch_clk,
  output logic o_frame_pulse,
  output logic o_tti_pulse,
  output logic o_cfn0_pulse,
  output logic o_frame80_pulse,
  output logic o_compressed,
  output logic [N_USER-1:0] o_user_out
);
  import wtio_pkg::*;

  localparam int CNT_W = $clog2(DATA_W + 1);

  // Configuration held in registers.
  logic sync_src;
  logic [2:0] fclk_sel;
  logic [2:0] slot_fmt;
  logic [1:0] tti_sel;
  logic [27:0] out_sel;
  logic [31:0] chip_inc;

  // Pin synchronisers: first stage, second stage, edge history.
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [3:0] pin_prev;
  wire logic [3:0] pin_edge;

  // Timing state.
  logic [31:0] acc;
  logic [11:0] slot_chip;
  logic [3:0] slot;
  logic [SFN_W-1:0] sfn;
  logic sync_pend;
  logic tpc_pend;
  logic [TPC_W-1:0] tpc;
  logic cm_req;
  logic [9:0] ctrl_word;
  logic [DATA_W-1:0] sh;
  logic [CNT_W-1:0] sh_cnt;

  wire logic [31:0] acc_sum;
  wire logic chip_tick;
  wire logic sc_last;
  wire logic fr_end;
  wire logic [SFN_W-1:0] sfn_mask;
  wire logic [SFN_W-1:0] sfn_aligned;
  wire logic [11:0] next_slot_chip;
  wire logic [3:0] next_slot;
  wire logic [SFN_W-1:0] next_sfn;
  wire logic frame_start;
  wire logic slot_start;
  wire logic [2:0] tti_mask;
  wire logic [2:0] fmt_eff;
  wire logic [7:0] dp_mask;
  wire logic [7:0] dp_pos;
  wire logic dp_edge;
  wire logic [3:0] cc_idx;
  wire logic f_valid;
  wire logic [DATA_W-1:0] f_data;
  wire logic f_pop;
  wire logic next_sync_pend;
  wire logic next_tpc_pend;
  wire logic [TPC_W-1:0] next_tpc;
  wire logic next_cm_req;
  wire logic [9:0] next_ctrl_word;
  wire logic [DATA_W-1:0] next_sh;
  wire logic [CNT_W-1:0] next_sh_cnt;

  // Next values of every timed output.
  wire logic next_chip_clk;
  wire logic next_reply;
  wire logic next_dp_bit;
  wire logic next_dp_clk;
  wire logic next_cc_bit;
  wire logic next_cc_clk;
  wire logic next_frame;
  wire logic next_tti;
  wire logic next_cfn0;
  wire logic next_f80;
  wire logic next_comp;
  wire logic [15:0] next_set;
  wire logic [N_USER-1:0] next_user;

  // Register port decode.
  wire logic wr_ctrl;
  wire logic wr_sel;
  wire logic wr_inc;
  wire logic [31:0] status_word;
  wire logic [31:0] ctrl_word_rd;
  wire logic [31:0] next_rdata;

  // Word buffer in the data channel path; its ready throttles the source.
  wtio_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_data_valid),
    .i_in_data(i_data),
    .o_in_ready(o_data_ready),
    .o_out_valid(f_valid),
    .o_out_data(f_data),
    .i_out_ready(f_pop)
  );

  // Two flip-flops before any logic reads a pin, then edge detection.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      pin_prev <= 4'h0;
    end else begin
      pin_meta <= {i_cm_stop, i_cm_start, i_tpc_trig, i_frame_sync};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end
  assign pin_edge = pin_sync & ~pin_prev;

  // Phase accumulator; its top bit is the chip clock.
  assign acc_sum = acc + chip_inc;
  assign chip_tick = ~acc[31] & acc_sum[31];
  assign next_chip_clk = acc_sum[31];

  // Sync input: frame clock aligns the frame number to its period.
  assign sfn_mask = (fclk_sel == FCLK_20MS) ? 12'h001 :
                    (fclk_sel == FCLK_40MS) ? 12'h003 :
                    (fclk_sel == FCLK_80MS) ? 12'h007 :
                    (fclk_sel == FCLK_2560MS) ? 12'h0ff :
                    12'h000;
  assign sfn_aligned = ((sfn & sfn_mask) == 12'h000) ? sfn :
                       (sfn | sfn_mask) + 12'h001;

  // Chip, slot and frame counters advance only on a chip edge.
  assign sc_last = slot_chip == SLOT_CHIP_LAST;
  assign fr_end = sc_last & (slot == SLOT_LAST);
  assign next_slot_chip = !chip_tick ? slot_chip :
                          (sync_pend | sc_last) ? 12'h000 :
                          slot_chip + 12'h001;
  assign next_slot = !chip_tick ? slot :
                     (sync_pend | fr_end) ? 4'h0 :
                     sc_last ? slot + 4'h1 : slot;
  assign next_sfn = !chip_tick ? sfn :
                    !sync_pend ? (fr_end ? sfn + 12'h001 : sfn) :
                    (sync_src == SYNC_SFN_RESET) ? 12'h000 :
                    sfn_aligned;
  assign frame_start = chip_tick & (sync_pend | fr_end);
  assign slot_start = chip_tick & (next_slot_chip == 12'h000);

  // Pending trigger flags; a new edge wins over the clear.
  assign next_sync_pend = pin_edge[0] | (sync_pend & ~chip_tick);
  assign next_tpc_pend = pin_edge[1] | (tpc_pend & ~slot_start);
  assign next_tpc = (slot_start & tpc_pend) ?
                    i_tpc_user_bits : tpc;
  assign next_cm_req = pin_edge[2] ? 1'b1 :
                       pin_edge[3] ? 1'b0 :
                       cm_req;

  // Frame-level pulses, each one chip period wide, and the compressed flag, which changes only at a frame start.
  assign tti_mask = (tti_sel == 2'h1) ? 3'h1 :
                    (tti_sel == 2'h2) ? 3'h3 :
                    (tti_sel == 2'h3) ? 3'h7 : 3'h0;
  assign next_reply = chip_tick ? sync_pend : o_sync_reply;
  assign next_frame = chip_tick ? frame_start : o_frame_pulse;
  assign next_tti = chip_tick ?
                    frame_start & ((next_sfn[2:0] & tti_mask) == 3'h0) :
                    o_tti_pulse;
  assign next_cfn0 = chip_tick ?
                     frame_start & (next_sfn[7:0] == 8'h00) :
                     o_cfn0_pulse;
  assign next_f80 = chip_tick ?
                    frame_start & (next_sfn[2:0] == 3'h0) :
                    o_frame80_pulse;
  assign next_comp = frame_start ? cm_req : o_compressed;

  // Data channel: spreading factor 256 >> format sets the bit period.
  assign fmt_eff = (slot_fmt > FMT_MAX) ? FMT_MAX : slot_fmt;
  assign dp_mask = 8'hff >> fmt_eff;
  assign dp_pos = next_slot_chip[7:0] & dp_mask;
  assign dp_edge = chip_tick & (dp_pos == 8'h00);
  assign next_dp_clk = chip_tick ?
                       (dp_pos <= (dp_mask >> 1)) : o_dpdch_clk;

  // Serialiser pulls a word when the last bit of the previous one is out.
  // An empty buffer sends zeros rather than stalling the air timing.
  assign f_pop = dp_edge & (sh_cnt <= CNT_W'(1));
  assign next_sh = !dp_edge ? sh :
                   (sh_cnt > CNT_W'(1)) ? {sh[DATA_W-2:0], 1'b0} :
                   f_valid ? f_data : '0;
  assign next_sh_cnt = !dp_edge ? sh_cnt :
                       (sh_cnt > CNT_W'(1)) ? sh_cnt - CNT_W'(1) :
                       f_valid ? CNT_W'(DATA_W) : '0;
  assign next_dp_bit = next_sh[DATA_W-1];

  // Control channel: ten bits per slot, 256 chips each, TPC last.
  assign cc_idx = next_slot_chip[11:8];
  assign next_ctrl_word = slot_start ?
                          {i_ctrl_fields, next_tpc} : ctrl_word;
  assign next_cc_clk = chip_tick ? ~next_slot_chip[7] :
                       o_dpcch_clk;
  assign next_cc_bit = chip_tick ?
                       next_ctrl_word[CTRL_BIT_LAST - cc_idx] :
                       o_dpcch_bit;

  // Signal set for the user ports, ordered as the selection codes.
  assign next_set = {4'h0, next_f80, next_cfn0, next_tti, next_comp,
                     next_reply, next_frame, next_cc_clk, next_cc_bit,
                     next_dp_clk, next_dp_bit, next_chip_clk, 1'b0};

  // Each port picks its signal from its own field of the select register.
  for (genvar g = 0; g < N_USER; g++) begin : g_user
    assign next_user[g] = next_set[out_sel[OUT_SEL_W*g +: OUT_SEL_W]];
  end

  // Register port decode and read mux.
  assign wr_ctrl = i_wr & (i_addr == REG_CTRL);
  assign wr_sel = i_wr & (i_addr == REG_OUT_SEL);
  assign wr_inc = i_wr & (i_addr == REG_CHIP_INC);
  assign ctrl_word_rd = (32'(sync_src) << CTRL_SYNC_SRC_BIT) |
                        (32'(fclk_sel) << CTRL_PERIOD_LSB) |
                        (32'(slot_fmt) << CTRL_FMT_LSB) |
                        (32'(tti_sel) << CTRL_TTI_LSB);
  assign status_word = 32'(sfn) |
                       (32'(o_compressed) << STAT_COMP_BIT) |
                       (32'(cm_req) << STAT_CMREQ_BIT);
  assign next_rdata = !i_rd ? 32'h0 :
                      (i_addr == REG_CTRL) ? ctrl_word_rd :
                      (i_addr == REG_OUT_SEL) ? 32'(out_sel) :
                      (i_addr == REG_CHIP_INC) ? chip_inc :
                      (i_addr == REG_STATUS) ? status_word :
                      32'h0;

  // Configuration registers; the chip rate reloads its default on reset.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync_src <= SYNC_FRAME_CLK;
      fclk_sel <= FCLK_10MS;
      slot_fmt <= 3'h0;
      tti_sel <= 2'h0;
      out_sel <= OUT_SEL_RST;
      chip_inc <= CHIP_INC_RST;
      o_rdata <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        sync_src <= i_wdata[CTRL_SYNC_SRC_BIT];
        fclk_sel <= i_wdata[CTRL_PERIOD_LSB +: 3];
        slot_fmt <= i_wdata[CTRL_FMT_LSB +: 3];
        tti_sel <= i_wdata[CTRL_TTI_LSB +: 2];
      end
      if (wr_sel) begin
        out_sel <= i_wdata[27:0];
      end
      if (wr_inc) begin
        chip_inc <= i_wdata;
      end
      o_rdata <= next_rdata;
    end
  end

  // Timing counters and pending flags.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      acc <= 32'h0;
      slot_chip <= 12'h000;
      slot <= 4'h0;
      sfn <= 12'h000;
      sync_pend <= 1'b0;
      tpc_pend <= 1'b0;
      tpc <= '0;
      cm_req <= 1'b0;
    end else begin
      acc <= acc_sum;
      slot_chip <= next_slot_chip;
      slot <= next_slot;
      sfn <= next_sfn;
      sync_pend <= next_sync_pend;
      tpc_pend <= next_tpc_pend;
      tpc <= next_tpc;
      cm_req <= next_cm_req;
    end
  end

  // Channel data paths.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_word <= 10'h000;
      sh <= '0;
      sh_cnt <= '0;
    end else begin
      ctrl_word <= next_ctrl_word;
      sh <= next_sh;
      sh_cnt <= next_sh_cnt;
    end
  end

  // Output flip-flops; all timed outputs move on the same chip edge, and the user ports also move when reselected.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_chip_clk <= 1'b0;
      o_sync_reply <= 1'b0;
      o_dpdch_bit <= 1'b0;
      o_dpdch_clk <= 1'b0;
      o_dpcch_bit <= 1'b0;
      o_dpcch_clk <= 1'b0;
      o_frame_pulse <= 1'b0;
      o_tti_pulse <= 1'b0;
      o_cfn0_pulse <= 1'b0;
      o_frame80_pulse <= 1'b0;
      o_compressed <= 1'b0;
      o_user_out <= '0;
    end else begin
      o_chip_clk <= next_chip_clk;
      o_sync_reply <= next_reply;
      o_dpdch_bit <= next_dp_bit;
      o_dpdch_clk <= next_dp_clk;
      o_dpcch_bit <= next_cc_bit;
      o_dpcch_clk <= next_cc_clk;
      o_frame_pulse <= next_frame;
      o_tti_pulse <= next_tti;
      o_cfn0_pulse <= next_cfn0;
      o_frame80_pulse <= next_f80;
      o_compressed <= next_comp;
      o_user_out <= next_user;
    end
  end
endmodule

`default_nettype wire

// ---- wtio_top_bench.sv ----
// Self-checking bench for the uplink timing block and its trigger model.
`timescale 1ns/1ps
`default_nettype none
module wtio_top_bench;
  import wtio_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] fire = 4'h0;
  logic slow = 1'b0;
  logic i_frame_sync, i_tpc_trig, i_cm_start, i_cm_stop;
  logic [TPC_W-1:0] i_tpc_user_bits = '0;
  logic [CTRL_FIELD_W-1:0] i_ctrl_fields = '0;
  logic i_data_valid = 1'b0;
  logic [7:0] i_data = 8'h00;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic o_data_ready, o_chip_clk, o_sync_reply, o_dpdch_bit, o_dpdch_clk;
  logic o_dpcch_bit, o_dpcch_clk, o_frame_pulse, o_tti_pulse, o_cfn0_pulse;
  logic o_frame80_pulse, o_compressed, cap = 1'b0, prev_dclk = 1'b0;
  logic [31:0] o_rdata;
  logic [6:0] o_user_out;
  logic [15:0] sigs;
  logic [31:0] rng = 32'h5124;
  logic bq[$];
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  logic [3:0] cmf[4] = '{4'h4, 4'h8, 4'hc, 4'h8};
  logic [2:0] pre[4] = '{3'h4, 3'h3, 3'h4, 3'h3};
  logic [2:0] post[4] = '{3'h7, 3'h0, 3'h7, 3'h0};

  wtio_top #(.DATA_W(8), .FIFO_DEPTH(16), .N_USER(7)) i_wtio_top (
    .i_clk, .i_rst_n, .i_frame_sync, .i_tpc_trig, .i_cm_start, .i_cm_stop,
    .i_tpc_user_bits, .i_ctrl_fields, .i_data_valid, .i_data, .o_data_ready,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_chip_clk, .o_sync_reply,
    .o_dpdch_bit, .o_dpdch_clk, .o_dpcch_bit, .o_dpcch_clk, .o_frame_pulse,
    .o_tti_pulse, .o_cfn0_pulse, .o_frame80_pulse, .o_compressed, .o_user_out
  );
  wtio_far_end i_wtio_far_end (
    .i_clk, .i_fire(fire), .i_slow(slow), .o_frame_sync(i_frame_sync),
    .o_tpc_trig(i_tpc_trig), .o_cm_start(i_cm_start), .o_cm_stop(i_cm_stop)
  );

  // Selectable signals, indexed by their output select code.
  assign sigs = {4'h0, o_frame80_pulse, o_cfn0_pulse, o_tti_pulse,
    o_compressed, o_sync_reply, o_frame_pulse, o_dpcch_clk, o_dpcch_bit,
    o_dpdch_clk, o_dpdch_bit, o_chip_clk, 1'b0};

  // Clock at 200 MHz.
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end

  // Serial data bits are caught at each rise of their own clock.
  always @(negedge i_clk) begin
    if (cap && o_dpdch_clk && !prev_dclk) bq.push_back(o_dpdch_bit);
    prev_dclk = o_dpdch_clk;
  end

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic [31:0] mk(logic s, logic [2:0] p, logic [2:0] f,
                                     logic [1:0] t);
    return {23'h0, t, f, p, s};
  endfunction

  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask

  task automatic pulse(input logic [3:0] k);
    repeat (14) @(posedge i_clk);
    fire <= k;
    slow <= rnd() > 32'h7fffffff;
    @(posedge i_clk);
    fire <= 4'h0;
  endtask

  task automatic wait_reply();
    int i;
    i = 0;
    while (o_sync_reply !== 1'b1 && i < 100) begin
      @(negedge i_clk);
      i++;
    end
    chk(32'(o_sync_reply), 32'h1);
  endtask

  // Cycles spanned by a number of periods of the chip, data or control bit clock.
  task automatic span(input int w, input int periods, output int n);
    logic p;
    int k;
    n = 0;
    k = 0;
    p = 1'b1;
    while (k <= periods && n < 9000) begin
      @(negedge i_clk);
      if (k > 0) n++;
      if (sigs[w] && !p) k++;
      p = sigs[w];
    end
  endtask

  // A hang is cut short well above the expected run length.
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    int n, ru, rs;
    logic pu, ps;
    logic [31:0] v;
    logic [9:0] word;
    logic [7:0] q[$];
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(REG_OUT_SEL, v);
    chk(v, {4'h0, OUT_SEL_RST});
    rd(REG_CHIP_INC, v);
    chk(v, CHIP_INC_RST);
    rd(8'h10, v);
    chk(v, 32'h0);
    wr(REG_STATUS, 32'hffffffff);
    rd(REG_STATUS, v);
    chk(v, 32'h0);
    span(1, 100, n);
    chk(32'(n >= 5207 && n <= 5209), 32'h1);
    // A faster chip clock keeps long counts short.
    wr(REG_CHIP_INC, 32'h40000000);
    for (int p = 0; p < 5; p++) begin
      wr(REG_CTRL, mk(p[0], p[2:0], 3'h6, p[1:0]));
      pulse(4'h1);
      wait_reply();
      chk(32'({o_frame_pulse, o_cfn0_pulse, o_tti_pulse, o_frame80_pulse}),
          32'hf);
      rd(REG_STATUS, v);
      chk(32'(v[11:0]), 32'h0);
    end
    // Mode requests only reach the flag at the next frame start.
    for (int s = 0; s < 4; s++) begin
      pulse(cmf[s]);
      repeat (20) @(posedge i_clk);
      rd(REG_STATUS, v);
      chk(32'({v[13:12], o_compressed}), 32'(pre[s]));
      pulse(4'h1);
      wait_reply();
      repeat (8) @(negedge i_clk);
      rd(REG_STATUS, v);
      chk(32'({v[13:12], o_compressed}), 32'(post[s]));
    end
    @(posedge i_clk);
    i_tpc_user_bits <= 2'(rnd());
    i_ctrl_fields <= 8'(rnd());
    pulse(4'h2);
    repeat (20) @(posedge i_clk);
    pulse(4'h1);
    wait_reply();
    word = {i_ctrl_fields, i_tpc_user_bits};
    repeat (511) @(negedge i_clk);
    for (int b = 9; b >= 0; b--) begin
      chk(32'(o_dpcch_bit), 32'(word[b]));
      repeat (1024) @(negedge i_clk);
    end
    for (int f = 0; f < 8; f++) begin
      wr(REG_CTRL, mk(1'b1, 3'h0, f[2:0], 2'h0));
      span(3, 1, n);
      span(3, 1, n);
      chk(n, (256 >> (f > 6 ? 6 : f)) * 4);
    end
    span(5, 1, n);
    chk(n, 256 * 4);
    // Fill the buffer until it refuses, then let it drain.
    cap <= 1'b1;
    @(posedge i_clk);
    i_data <= 8'h80 | 8'(rnd());
    i_data_valid <= 1'b1;
    n = 0;
    while (n < 40) begin
      @(negedge i_clk);
      v[0] = o_data_ready;
      @(posedge i_clk);
      if (!v[0]) break;
      q.push_back(i_data);
      i_data <= 8'(rnd());
      n++;
    end
    i_data_valid <= 1'b0;
    chk(32'(n >= 16 && n <= 18), 32'h1);
    repeat ((n + 4) * 128) @(negedge i_clk);
    cap <= 1'b0;
    while (bq.size() > 0 && bq[0] === 1'b0) void'(bq.pop_front());
    foreach (q[w]) begin
      for (int b = 7; b >= 0; b--)
        chk(32'(bq.pop_front()), 32'(q[w][b]));
    end
    foreach (bq[i]) chk(32'(bq[i]), 32'h0);
    for (int c = 0; c < 16; c++) begin
      wr(REG_OUT_SEL, {4'h0, {7{c[3:0]}}});
      repeat (4) @(negedge i_clk);
      pu = 1'b1;
      ps = 1'b1;
      ru = 0;
      rs = 0;
      repeat (200) begin
        @(negedge i_clk);
        ru += int'(o_user_out[0] && !pu);
        rs += int'(sigs[c] && !ps);
        pu = o_user_out[0];
        ps = sigs[c];
      end
      chk(32'(ru <= rs + 1 && rs <= ru + 1 && (rs > 0 || ru == 0)),
          32'h1);
      if (rs == 0) chk(32'(o_user_out), 32'({7{ps}}));
    end
    conclude();
  end
endmodule
`default_nettype wire

// ---- wtio_top_sva.sv ----
// Property checker for the uplink timing block, bound to its ports.
`timescale 1ns/1ps
`default_nettype none
module wtio_top_sva (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_frame_sync,
  input wire logic o_chip_clk,
  input wire logic o_sync_reply,
  input wire logic o_dpdch_bit,
  input wire logic o_dpdch_clk,
  input wire logic o_dpcch_bit,
  input wire logic o_dpcch_clk,
  input wire logic o_frame_pulse,
  input wire logic o_tti_pulse,
  input wire logic o_cfn0_pulse,
  input wire logic o_frame80_pulse,
  input wire logic o_compressed
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] since_sync;
  logic [7:0] hi_chips;

  // Cycles since a sync edge; it rests at the top so a stray reply shows.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      since_sync <= 8'hff;
    end else if ($rose(i_frame_sync)) begin
      since_sync <= 8'h00;
    end else if (since_sync != 8'hff) begin
      since_sync <= since_sync + 8'h01;
    end
  end

  // Chips since the control bit clock last started its high half.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hi_chips <= 8'h00;
    end else if ($rose(o_chip_clk)) begin
      hi_chips <= ($rose(o_dpcch_clk) || $rose(o_sync_reply)) ? 8'h00
                  : hi_chips + 8'h01;
    end
  end

  a_data_chip_edge:
    assert property (($changed(o_dpdch_bit) || $changed(o_dpcch_bit) ||
      $changed(o_dpdch_clk) || $changed(o_dpcch_clk)) |-> $rose(o_chip_clk))
    else $error("data output moved off a chip edge");
  a_pulse_chip_edge:
    assert property (($changed(o_sync_reply) || $changed(o_frame_pulse) ||
      $changed(o_tti_pulse)) |-> $rose(o_chip_clk))
    else $error("pulse output moved off a chip edge");
  a_flag_frame_edge:
    assert property ($changed(o_compressed) |->
      $rose(o_chip_clk) && $rose(o_frame_pulse))
    else $error("compressed flag moved off a frame start");
  a_reply_has_cause:
    assert property ($rose(o_sync_reply) |-> since_sync < 8'd100)
    else $error("sync reply without a trigger");
  a_trig_answered:
    assert property ($rose(i_frame_sync) |-> ##[3:100] $rose(o_sync_reply))
    else $error("sync trigger left without reply");
  a_reply_frame:
    assert property ($rose(o_sync_reply) |->
      $rose(o_frame_pulse) && $rose(o_chip_clk))
    else $error("sync did not restart the frame");
  a_frame_one_chip:
    assert property ($rose(o_frame_pulse) |=>
      (o_frame_pulse until $rose(o_chip_clk)))
    else $error("frame pulse shorter than a chip");
  a_frame_drops:
    assert property ($rose(o_frame_pulse) |-> ##[1:60] !o_frame_pulse)
    else $error("frame pulse longer than a chip");
  a_tti_in_frame:
    assert property (o_tti_pulse |-> o_frame_pulse)
    else $error("interval pulse off a frame boundary");
  a_cfn0_nested:
    assert property (o_cfn0_pulse |->
      o_frame80_pulse && o_tti_pulse && o_frame_pulse)
    else $error("frame zero pulse without its companions");
  a_f80_in_frame:
    assert property (o_frame80_pulse |-> o_frame_pulse)
    else $error("80 ms pulse off a frame boundary");
  a_ctrl_clk_half:
    assert property ($fell(o_dpcch_clk) |-> hi_chips == 8'd127)
    else $error("control bit clock high half is not 128 chips");
endmodule

bind wtio_top wtio_top_sva i_wtio_top_sva (
  .i_clk, .i_rst_n, .i_frame_sync, .o_chip_clk, .o_sync_reply,
  .o_dpdch_bit, .o_dpdch_clk, .o_dpcch_bit, .o_dpcch_clk, .o_frame_pulse,
  .o_tti_pulse, .o_cfn0_pulse, .o_frame80_pulse, .o_compressed
);
`default_nettype wire
